// File: common/npr_map.vh
// Register map, command codes and timing counts of the NOR flash controller.
// Assumes a 100 MHz hclk and a flash in word mode with 26 word address bits.
`ifndef NPR_MAP_VH
`define NPR_MAP_VH
// Register offsets on the bus
`define NPR_OFF_CMD 12'h000
`define NPR_OFF_CFG 12'h004
`define NPR_OFF_ADDR 12'h008
`define NPR_OFF_WDATA 12'h00c
`define NPR_OFF_COUNT 12'h010
`define NPR_OFF_BUFLD 12'h014
`define NPR_OFF_STAT 12'h018
`define NPR_OFF_RDATA 12'h01c
// Field positions
`define NPR_CFG_SKIP 0
`define NPR_ST_BUSY 0
`define NPR_ST_ABP 1
`define NPR_ST_ERR 2
`define NPR_ST_POLL 3
`define NPR_ST_TOG 4
`define NPR_ST_TLIM 5
`define NPR_ST_BABT 6
`define NPR_ST_RVLD 7
`define NPR_DQ_POLL 7
`define NPR_DQ_TOG 6
`define NPR_DQ_TLIM 5
`define NPR_DQ_BABT 1
// Operation codes written to the command register
`define NPR_OP_CLRBUF 3'h0
`define NPR_OP_READ 3'h1
`define NPR_OP_PROG 3'h2
`define NPR_OP_BUF 3'h3
`define NPR_OP_ARST 3'h4
`define NPR_OP_SUSP 3'h5
`define NPR_OP_RES 3'h6
`define NPR_OP_HWRST 3'h7
// Flash command words and unlock addresses
`define NPR_UA1 26'h0000555
`define NPR_UA2 26'h00002aa
`define NPR_CD_UNL1 16'h00aa
`define NPR_CD_UNL2 16'h0055
`define NPR_CD_PROG 16'h00a0
`define NPR_CD_BUFLD 16'h0025
`define NPR_CD_CONF 16'h0029
`define NPR_CD_ARST 16'h00f0
`define NPR_CD_SUSP 16'h00b0
`define NPR_CD_RES 16'h0030
`define NPR_BUF_LAST 6'h1f
// Reset values
`define NPR_RST_CFG 1'h0
`define NPR_RST_ADDR 26'h0000000
`define NPR_RST_DATA 16'h0000
// Timing in ns and derived cycle counts (least times round up)
`define NPR_CLK_MHZ 100
`define NPR_T_ACC_NS 120
`define NPR_T_PACC_NS 25
`define NPR_T_WP_NS 35
`define NPR_T_RP_NS 500
`define NPR_T_READY_NS 20000
`define NPR_ACC_CYC ((`NPR_T_ACC_NS * `NPR_CLK_MHZ + 999) / 1000)
`define NPR_PACC_CYC ((`NPR_T_PACC_NS * `NPR_CLK_MHZ + 999) / 1000)
`define NPR_WP_CYC ((`NPR_T_WP_NS * `NPR_CLK_MHZ + 999) / 1000)
`define NPR_RP_CYC ((`NPR_T_RP_NS * `NPR_CLK_MHZ + 999) / 1000)
`define NPR_READY_CYC ((`NPR_T_READY_NS * `NPR_CLK_MHZ + 999) / 1000)
`endif

// File: hw/npr_sync.v
// Two-stage synchroniser for a bus of asynchronous pin inputs.
// Assumes the bits are sampled words that settle well before they are used.
`timescale 1ns/1ns
module npr_sync #(
   parameter W = 16
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   // Data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] s1_r;

   // First stage feeds only the second
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= {W{1'b0}};
         q <= {W{1'b0}};
      end else if (clk_en) begin
         s1_r <= d;
         q <= s1_r;
      end
   end
endmodule // npr_sync

// File: hw/npr_pincyc.v
// One flash bus cycle: a command write or an array read on the flash pins.
// Assumes dq_sync is the flash data already passed through two flip-flops.
`timescale 1ns/1ns
`include "npr_map.vh"
module npr_pincyc (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   // Request
   input wire start,
   input wire wr,
   input wire [25:0] addr,
   input wire [15:0] wdata,
   output wire busy,
   output reg done,
   output reg [15:0] rdata,
   // Flash pins
   input wire [15:0] dq_sync,
   output reg f_ce_n,
   output reg f_oe_n,
   output reg f_we_n,
   output reg [25:0] f_addr,
   output reg [15:0] f_dq_out,
   output reg f_dq_oe
);
   localparam [1:0] P_IDLE = 2'h0;
   localparam [1:0] P_SET = 2'h1;
   localparam [1:0] P_STB = 2'h2;
   localparam [1:0] P_HLD = 2'h3;
   // Two extra cycles cover the input synchroniser
   localparam integer ACC_C = `NPR_ACC_CYC + 2;
   localparam integer PACC_C = `NPR_PACC_CYC + 2;
   localparam integer WP_C = `NPR_WP_CYC;
   reg [1:0] st_r;
   reg [11:0] cnt_r;
   reg [11:0] lim_r;
   reg wr_r;
   reg pg_vld_r;
   reg [22:0] pg_r;
   wire hit = pg_vld_r && !wr && (addr[25:3] == pg_r);

   assign busy = (st_r != P_IDLE);

   // Cycle sequencer; select stays low after a read to keep the page open
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= P_IDLE;
         cnt_r <= 12'h000;
         lim_r <= 12'h001;
         wr_r <= 1'b0;
         pg_vld_r <= 1'b0;
         pg_r <= 23'h000000;
         done <= 1'b0;
         rdata <= 16'h0000;
         f_ce_n <= 1'b1;
         f_oe_n <= 1'b1;
         f_we_n <= 1'b1;
         f_addr <= 26'h0000000;
         f_dq_out <= 16'h0000;
         f_dq_oe <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         cnt_r <= cnt_r + 12'h001;
         case (st_r)
            P_IDLE: begin
               if (start) begin
                  st_r <= P_SET;
                  wr_r <= wr;
                  f_addr <= addr;
                  f_ce_n <= 1'b0;
                  f_dq_out <= wdata;
                  f_dq_oe <= wr;
                  lim_r <= wr ? WP_C[11:0] : (hit ? PACC_C[11:0] : ACC_C[11:0]);
               end
            end
            P_SET: begin
               st_r <= P_STB;
               cnt_r <= 12'h001;
               if (wr_r) begin
                  f_we_n <= 1'b0;
               end else begin
                  f_oe_n <= 1'b0;
               end
            end
            P_STB: begin
               if (cnt_r >= lim_r) begin
                  if (wr_r) begin
                     st_r <= P_HLD;
                     f_we_n <= 1'b1;
                  end else begin
                     st_r <= P_IDLE;
                     rdata <= dq_sync;
                     f_oe_n <= 1'b1;
                     done <= 1'b1;
                     pg_vld_r <= 1'b1;
                     pg_r <= f_addr[25:3];
                  end
               end
            end
            P_HLD: begin
               // Data still driven past the write rise; select then released
               st_r <= P_IDLE;
               f_ce_n <= 1'b1;
               f_dq_oe <= 1'b0;
               pg_vld_r <= 1'b0;
               done <= 1'b1;
            end
            default: st_r <= P_IDLE;
         endcase
      end
   end
endmodule // npr_pincyc

// File: hw/npr_ctrl.v
// Host controller for a parallel NOR flash: AHB-Lite register slave plus
// command sequencer for page reads, single and buffered program.
// Assumes one flash on the pins, word mode, and a single AHB master.
`timescale 1ns/1ns
`include "npr_map.vh"
module npr_ctrl (
   // Clock, reset, enable
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Flash pins
   output wire flash_ce_n,
   output wire flash_oe_n,
   output wire flash_we_n,
   output reg flash_rst_n,
   output wire [25:0] flash_addr,
   input wire [15:0] flash_dq_in,
   output wire [15:0] flash_dq_out,
   output wire flash_dq_oe
);
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_UNL1 = 4'h1;
   localparam [3:0] S_UNL2 = 4'h2;
   localparam [3:0] S_SETUP = 4'h3;
   localparam [3:0] S_COUNT = 4'h4;
   localparam [3:0] S_LOAD = 4'h5;
   localparam [3:0] S_CONF = 4'h6;
   localparam [3:0] S_TGT = 4'h7;
   localparam [3:0] S_READ = 4'h8;
   localparam [3:0] S_RSTLO = 4'h9;
   localparam [3:0] S_RSTWT = 4'ha;
   localparam integer RP_C = `NPR_RP_CYC;
   localparam integer READY_C = `NPR_READY_CYC;

   // Bus state
   reg wr_ph_r;
   reg [11:0] wa_r;
   // Software registers
   reg [2:0] op_r;
   reg skip_r;
   reg [25:0] addr_r;
   reg [15:0] wdata_r;
   reg [5:0] count_r;
   reg [5:0] wptr_r;
   reg [4:0] boff [0:31];
   reg [15:0] bdat [0:31];
   // Sequencer and status
   reg [3:0] st_r;
   reg [3:0] st_nxt;
   reg [3:0] first_nxt;
   reg iss_r;
   reg [5:0] lidx_r;
   reg [25:0] last_r;
   reg [11:0] tcnt_r;
   reg abp_r;
   reg err_r;
   reg [15:0] rd_r;
   reg tog_r;
   reg rvld_r;
   reg [25:0] cyc_addr;
   reg [15:0] cyc_data;
   reg [31:0] rd_mux;
   wire cyc_busy;
   wire cyc_done;
   wire [15:0] cyc_rdata;
   wire [15:0] dq_sync;

   // Zero-wait slave; a frozen clock enable stretches the data phase
   assign hreadyout = clk_en;
   assign hresp = 1'b0;
   wire acc = hsel && htrans[1] && hready && clk_en;
   wire we_go = wr_ph_r && clk_en;
   wire cmd_go = we_go && (wa_r == `NPR_OFF_CMD);
   wire idle = (st_r == S_IDLE);
   wire [2:0] new_op = hwdata[2:0];
   // While an abort is pending only the abort reset, hardware reset and reads pass
   wire op_ok = idle && (!abp_r || new_op == `NPR_OP_ARST ||
                new_op == `NPR_OP_HWRST || new_op == `NPR_OP_READ);
   wire bl_go = we_go && (wa_r == `NPR_OFF_BUFLD) && idle && !wptr_r[5];
   wire bus_st = (st_r != S_IDLE) && (st_r <= S_READ);
   wire cyc_start = bus_st && !iss_r && !cyc_busy;
   wire is_wr = (st_r != S_READ);
   wire lds_done = (lidx_r == count_r);

   // Address phase capture and registered read data
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_r <= 1'b0;
         wa_r <= 12'h000;
         hrdata <= 32'h00000000;
      end else if (clk_en) begin
         wr_ph_r <= acc && hwrite;
         if (acc) begin
            wa_r <= haddr[11:0];
         end
         if (acc && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Read mux; unmapped offsets read as zero
   always @* begin
      rd_mux = 32'h00000000;
      case (haddr[11:0])
         `NPR_OFF_CMD: rd_mux[2:0] = op_r;
         `NPR_OFF_CFG: rd_mux[`NPR_CFG_SKIP] = skip_r;
         `NPR_OFF_ADDR: rd_mux[25:0] = addr_r;
         `NPR_OFF_WDATA: rd_mux[15:0] = wdata_r;
         `NPR_OFF_COUNT: rd_mux[5:0] = count_r;
         `NPR_OFF_BUFLD: rd_mux[5:0] = wptr_r;
         `NPR_OFF_STAT: begin
            rd_mux[`NPR_ST_BUSY] = !idle;
            rd_mux[`NPR_ST_ABP] = abp_r;
            rd_mux[`NPR_ST_ERR] = err_r;
            rd_mux[`NPR_ST_POLL] = rd_r[`NPR_DQ_POLL];
            rd_mux[`NPR_ST_TOG] = tog_r;
            rd_mux[`NPR_ST_TLIM] = rd_r[`NPR_DQ_TLIM];
            rd_mux[`NPR_ST_BABT] = rd_r[`NPR_DQ_BABT];
            rd_mux[`NPR_ST_RVLD] = rvld_r;
         end
         `NPR_OFF_RDATA: rd_mux[15:0] = rd_r;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Buffer storage; any offset order and repeats are kept as written
   always @(posedge hclk) begin
      if (clk_en && bl_go) begin
         boff[wptr_r[4:0]] <= hwdata[20:16];
         bdat[wptr_r[4:0]] <= hwdata[15:0];
      end
   end

   // First step of each operation
   always @* begin
      case (new_op)
         `NPR_OP_READ: first_nxt = S_READ;
         `NPR_OP_PROG: first_nxt = skip_r ? S_SETUP : S_UNL1;
         `NPR_OP_BUF: first_nxt = skip_r ? S_SETUP : S_UNL1;
         `NPR_OP_ARST: first_nxt = S_UNL1;
         `NPR_OP_SUSP: first_nxt = S_SETUP;
         `NPR_OP_RES: first_nxt = S_SETUP;
         `NPR_OP_HWRST: first_nxt = S_RSTLO;
         default: first_nxt = S_IDLE;
      endcase
   end

   // Step order once a bus cycle completes
   always @* begin
      case (st_r)
         S_UNL1: st_nxt = S_UNL2;
         S_UNL2: st_nxt = S_SETUP;
         S_SETUP: begin
            if (op_r == `NPR_OP_PROG) begin
               st_nxt = S_TGT;
            end else if (op_r == `NPR_OP_BUF) begin
               st_nxt = S_COUNT;
            end else begin
               st_nxt = S_IDLE;
            end
         end
         // Oversized count: the flash aborts, so loading stops here
         S_COUNT: st_nxt = (count_r > `NPR_BUF_LAST) ? S_IDLE : S_LOAD;
         S_LOAD: st_nxt = lds_done ? S_CONF : S_LOAD;
         default: st_nxt = S_IDLE;
      endcase
   end

   // Address and data of the current flash write
   always @* begin
      cyc_addr = addr_r;
      cyc_data = 16'h0000;
      case (st_r)
         S_UNL1: begin
            cyc_addr = `NPR_UA1;
            cyc_data = `NPR_CD_UNL1;
         end
         S_UNL2: begin
            cyc_addr = `NPR_UA2;
            cyc_data = `NPR_CD_UNL2;
         end
         S_SETUP: begin
            case (op_r)
               `NPR_OP_PROG: begin
                  cyc_addr = `NPR_UA1;
                  cyc_data = `NPR_CD_PROG;
               end
               `NPR_OP_BUF: cyc_data = `NPR_CD_BUFLD;
               `NPR_OP_ARST: begin
                  cyc_addr = `NPR_UA1;
                  cyc_data = `NPR_CD_ARST;
               end
               `NPR_OP_SUSP: cyc_data = `NPR_CD_SUSP;
               default: cyc_data = `NPR_CD_RES;
            endcase
         end
         S_COUNT: cyc_data = {10'h000, count_r};
         // All loads share the page of the target address from bit five up
         S_LOAD: begin
            cyc_addr = {addr_r[25:5], boff[lidx_r[4:0]]};
            cyc_data = bdat[lidx_r[4:0]];
         end
         S_CONF: begin
            cyc_addr = last_r;
            cyc_data = `NPR_CD_CONF;
         end
         S_TGT: cyc_data = wdata_r;
         default: cyc_data = 16'h0000;
      endcase
   end

   // Registers, sequencer and status
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_r <= `NPR_OP_CLRBUF;
         skip_r <= `NPR_RST_CFG;
         addr_r <= `NPR_RST_ADDR;
         wdata_r <= `NPR_RST_DATA;
         count_r <= 6'h00;
         wptr_r <= 6'h00;
         st_r <= S_IDLE;
         iss_r <= 1'b0;
         lidx_r <= 6'h00;
         last_r <= `NPR_RST_ADDR;
         tcnt_r <= 12'h000;
         abp_r <= 1'b0;
         err_r <= 1'b0;
         rd_r <= `NPR_RST_DATA;
         tog_r <= 1'b0;
         rvld_r <= 1'b0;
         flash_rst_n <= 1'b1;
      end else if (clk_en) begin
         if (we_go && idle) begin
            if (wa_r == `NPR_OFF_CFG) skip_r <= hwdata[`NPR_CFG_SKIP];
            if (wa_r == `NPR_OFF_ADDR) addr_r <= hwdata[25:0];
            if (wa_r == `NPR_OFF_WDATA) wdata_r <= hwdata[15:0];
            if (wa_r == `NPR_OFF_COUNT) count_r <= hwdata[5:0];
         end
         if (bl_go) wptr_r <= wptr_r + 6'h01;
         // Error flag: write one to clear, a new refusal wins
         if (we_go && wa_r == `NPR_OFF_STAT && hwdata[`NPR_ST_ERR]) err_r <= 1'b0;
         if ((cmd_go && !op_ok) || (we_go && !idle && wa_r != `NPR_OFF_STAT)) begin
            err_r <= 1'b1;
         end
         if (cyc_start) iss_r <= 1'b1;
         case (st_r)
            S_IDLE: begin
               if (cmd_go && op_ok) begin
                  op_r <= new_op;
                  st_r <= first_nxt;
                  lidx_r <= 6'h00;
                  if (new_op == `NPR_OP_CLRBUF) wptr_r <= 6'h00;
               end
            end
            S_RSTLO: begin
               // Hardware reset pulse ends any program in the flash
               flash_rst_n <= 1'b0;
               tcnt_r <= tcnt_r + 12'h001;
               if (tcnt_r >= RP_C[11:0]) begin // Low for the whole RP_C count
                  st_r <= S_RSTWT;
                  tcnt_r <= 12'h000;
                  flash_rst_n <= 1'b1;
               end
            end
            S_RSTWT: begin
               tcnt_r <= tcnt_r + 12'h001;
               if (tcnt_r >= READY_C[11:0] - 12'h001) begin
                  st_r <= S_IDLE;
                  tcnt_r <= 12'h000;
                  abp_r <= 1'b0;
               end
            end
            default: begin
               if (cyc_done) begin
                  iss_r <= 1'b0;
                  st_r <= st_nxt;
                  if (st_r == S_LOAD) begin
                     lidx_r <= lidx_r + 6'h01;
                     last_r <= cyc_addr;
                  end
                  if (st_r == S_COUNT && count_r > `NPR_BUF_LAST) abp_r <= 1'b1;
                  if (st_r == S_CONF) wptr_r <= 6'h00;
                  if (st_r == S_SETUP && op_r == `NPR_OP_ARST) abp_r <= 1'b0;
                  if (st_r == S_READ) begin
                     rd_r <= cyc_rdata;
                     tog_r <= cyc_rdata[`NPR_DQ_TOG] ^ rd_r[`NPR_DQ_TOG];
                     rvld_r <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Flash data input synchroniser
   npr_sync #(
      .W(16)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .d(flash_dq_in),
      .q(dq_sync)
   );

   // Pin cycle engine
   npr_pincyc u_cyc (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .start(cyc_start),
      .wr(is_wr),
      .addr(cyc_addr),
      .wdata(cyc_data),
      .busy(cyc_busy),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .dq_sync(dq_sync),
      .f_ce_n(flash_ce_n),
      .f_oe_n(flash_oe_n),
      .f_we_n(flash_we_n),
      .f_addr(flash_addr),
      .f_dq_out(flash_dq_out),
      .f_dq_oe(flash_dq_oe)
   );
endmodule // npr_ctrl

// File: testbench/npr_ctrl_props.sv
// Checker of the flash pin timing, bound to the controller top.
// Assumes clk_en stays high while flash traffic runs.
`timescale 1ns/1ns
module npr_ctrl_props (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Flash pins
   input wire flash_ce_n,
   input wire flash_oe_n,
   input wire flash_we_n,
   input wire flash_rst_n,
   input wire [25:0] flash_addr,
   input wire [15:0] flash_dq_out,
   input wire flash_dq_oe
);
   logic [7:0] rcnt;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Length of the hardware reset pulse so far
   always @(posedge hclk or negedge hresetn)
      if (!hresetn) rcnt <= 8'h0;
      else rcnt <= flash_rst_n ? 8'h0 : rcnt + 8'h1;
   // Write strobe low four cycles, then high
   sequence we_pulse_s;
      !flash_we_n [*4] ##1 flash_we_n;
   endsequence
   // Select held one cycle past the strobe
   sequence ce_drop_s;
      !flash_ce_n ##1 flash_ce_n;
   endsequence
   we_width_a: assert property ($fell(flash_we_n) |-> we_pulse_s)
      else $error("write pulse width wrong");
   write_strobes_a: assert property (!flash_we_n |->
      !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("write strobes wrong");
   write_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_out))
      else $error("write address or data moved");
   ce_release_a: assert property ($rose(flash_we_n) |-> ce_drop_s)
      else $error("select not released after write");
   data_after_a: assert property ($rose(flash_we_n) |->
      $stable(flash_dq_out) && flash_dq_oe)
      else $error("data not held past strobe rise");
   read_strobes_a: assert property (!flash_oe_n |->
      !flash_ce_n && flash_we_n && !flash_dq_oe)
      else $error("read strobes wrong");
   reset_pulse_a: assert property ($rose(flash_rst_n) |-> rcnt == 8'd50)
      else $error("reset pulse length wrong");
   reset_quiet_a: assert property (!flash_rst_n |-> flash_we_n)
      else $error("write during flash reset");
endmodule // npr_ctrl_props
bind npr_ctrl npr_ctrl_props npr_ctrl_props_inst (.hclk(hclk), .hresetn(hresetn),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .flash_rst_n(flash_rst_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
   .flash_dq_oe(flash_dq_oe));

// File: testbench/npr_flash_model.sv
// Behavioural NOR flash: command decode, program, buffer and status.
// Assumes word mode; only the low 256 words are stored.
`timescale 1ns/1ns
module npr_flash_model (
   // Pins
   input wire ce_n,
   input wire oe_n,
   input wire we_n,
   input wire rst_n,
   input wire skip_en,
   input wire [25:0] addr,
   input wire [15:0] din,
   output logic [15:0] dq
);
   logic [15:0] mem [0:255];
   logic [15:0] bw [0:31];
   logic [31:0] vm;
   logic [25:0] la, sa;
   logic [20:0] pg;
   logic [15:0] pd;
   logic bsy = 0, tog = 0, fst;
   int st = 0, rem, errs = 0;
   // Erased array
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
      dq = 16'h0;
   end
   // Address on the later falling strobe
   always @(negedge we_n) if (!ce_n) la = addr;
   // Commands on the earlier rising strobe; ignored while busy
   always @(posedge we_n) if (!ce_n && rst_n && !bsy) begin
      case (st)
         0: if (din == 16'haa && la == 26'h555) st = 1;
            else if (skip_en && din == 16'ha0) st = 3;
            else if (din != 16'hf0 && din != 16'hb0 && din != 16'h30) st = 9;
         1: st = (din == 16'h55 && la == 26'h2aa) ? 2 : 9;
         2: if (din == 16'ha0 && la == 26'h555) st = 3;
            else if (din == 16'h25) begin
               sa = la;
               st = 4;
            end
            else st = (din == 16'hf0) ? 0 : 9;
         3: begin
            mem[la[7:0]] &= din;
            pd = din;
            bsy = 1;
         end
         4: if (la[25:16] != sa[25:16]) st = 9;
            else if (din > 16'd31) st = 8;
            else begin
               rem = din + 1;
               vm = 0;
               fst = 1;
               st = 5;
            end
         5: begin
            if (fst) pg = la[25:5];
            fst = 0;
            if (la[25:5] != pg || la[25:16] != sa[25:16]) st = 8;
            else begin
               bw[la[4:0]] = din;
               vm[la[4:0]] = 1;
               pd = din;
               rem--;
               if (rem == 0) st = 6;
            end
         end
         6: if (din == 16'h29 && la[25:16] == sa[25:16]) begin
               for (int i = 0; i < 32; i++) if (vm[i]) mem[{pg[2:0], i[4:0]}] &= bw[i];
               bsy = 1;
            end
            else st = 8;
         8: if (din == 16'hf0) st = 0;
         default: st = 9;
      endcase
      if (st == 9) begin
         errs++;
         st = 0;
      end
   end
   // Embedded phase lasts a fixed time, then array read again
   always @(posedge bsy) begin
      #250;
      bsy = 0;
      st = 0;
   end
   // Hardware reset ends any operation at once
   always @(negedge rst_n) begin
      bsy = 0;
      st = 0;
   end
   // Status replaces array data while busy or aborted
   always @(negedge oe_n) if (!ce_n) begin
      if (bsy || st == 8) begin
         tog = ~tog;
         dq = {8'h0, ~pd[7], tog, 1'b0, 3'h0, st == 8, 1'b0};
      end
      else dq = mem[addr[7:0]];
   end
   // Released bus shows no stale value
   always @(posedge oe_n) dq = ~dq;
endmodule // npr_flash_model

// File: testbench/tb_npr_ctrl.sv
// Self-checking bench: AHB-Lite register calls against the flash model.
// Assumes zero wait states and one flash on the pins.
`timescale 1ns/1ns
module tb_npr_ctrl;
   logic hclk = 0, hresetn, hsel, hwrite, skip;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, q;
   wire hreadyout, hresp, ce_n, oe_n, we_n, rst_n, dq_oe;
   wire [31:0] hrdata;
   wire [25:0] fa;
   wire [15:0] dq_out, fdq, dqw;
   int mismatches, samples_checked, r, olen, olast, lens[2];
   assign dqw = dq_oe ? dq_out : fdq;
   npr_ctrl npr_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_rst_n(rst_n),
      .flash_addr(fa), .flash_dq_in(dqw), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
   npr_flash_model npr_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .rst_n(rst_n), .skip_en(skip), .addr(fa), .din(dqw), .dq(fdq));
   // Clock and read-strobe length meter
   always #5 hclk = ~hclk;
   always @(posedge hclk) olen <= oe_n ? 0 : olen + 1;
   always @(posedge oe_n) olast = olen;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // One single transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
      q = hrdata;
      if (n >= 50) begin
         mismatches++;
         stop_test;
      end
   endtask
   // Command, then wait until the sequencer is idle
   task automatic op(input logic [2:0] c);
      ahb(1, 12'h000, {29'h0, c});
      for (int n = 0; n < 4000; n++) begin
         ahb(0, 12'h018, 0);
         if (q[0] === 1'b0) return;
      end
      mismatches++;
      stop_test;
   endtask
   // Read a flash word until it matches, counting tries
   task automatic fread(input logic [31:0] a, e);
      ahb(1, 12'h008, a);
      for (r = 0; r < 20; r++) begin
         op(1);
         if (r < 2) lens[r] = olast;
         ahb(0, 12'h01c, 0);
         if (q === e) break;
      end
      chk("flash_data", e, q);
   endtask
   initial begin
      {hresetn, hwrite, skip, htrans, haddr, hwdata} = 0;
      hsel = 1;
      repeat (12) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      ahb(0, 12'h004, 0);
      chk("cfg_rst", 0, q);
      ahb(0, 12'h018, 0);
      chk("stat_rst", 0, q);
      chk("hresp_okay", 0, hresp);
      ahb(0, 12'h020, 0);
      chk("unmapped", 0, q);
      $display("test reset done");
      ahb(1, 12'h008, 32'h10);
      ahb(1, 12'h00c, 32'h12f0);
      op(2);
      fread(32'h10, 32'h12f0);
      chk("busy_seen", 1, r > 0);
      chk("page_hit", 1, lens[1] < lens[0]);
      ahb(1, 12'h00c, 32'hff0f);
      op(2);
      fread(32'h10, 32'h1200);
      skip <= 1;
      ahb(1, 12'h004, 32'h1);
      ahb(1, 12'h008, 32'h20);
      ahb(1, 12'h00c, 32'h3456);
      op(2);
      fread(32'h20, 32'h3456);
      ahb(1, 12'h004, 32'h0);
      skip <= 0;
      $display("test single program done");
      op(0);
      ahb(1, 12'h008, 32'h40);
      ahb(1, 12'h010, 32'h2);
      ahb(1, 12'h014, 32'h11111);
      ahb(1, 12'h014, 32'h12222);
      ahb(1, 12'h014, 32'h23333);
      op(3);
      fread(32'h41, 32'h2222);
      fread(32'h42, 32'h3333);
      op(5);
      op(6);
      ahb(0, 12'h000, 0);
      chk("last_op", 6, q);
      $display("test buffer program done");
      ahb(1, 12'h010, 32'h20);
      op(3);
      op(1);
      op(1);
      ahb(0, 12'h018, 0);
      chk("abort_pend", 1, q[1]);
      chk("abort_dq", 4'b1011, q[6:3]);
      ahb(1, 12'h000, 32'h2);
      ahb(0, 12'h018, 0);
      chk("refused", 3'b011, q[2:1]);
      ahb(1, 12'h018, 32'h4);
      op(4);
      ahb(0, 12'h018, 0);
      chk("abort_clr", 0, q[2:1]);
      ahb(1, 12'h010, 32'h20);
      op(3);
      op(7);
      ahb(0, 12'h018, 0);
      chk("hwrst_clr", 0, q[1]);
      chk("model_seq", 0, npr_flash_model_inst.errs);
      $display("test abort and reset done");
      stop_test;
   end
endmodule // tb_npr_ctrl
